// file: src/dcf_device.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_device
   import dcf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [PTR_W-1:0] empty_offset,
   input wire logic [PTR_W-1:0] full_offset,
   output logic fall_through_mode,
   dcf_if.fifo link
);
   logic [DEV_SYNC_W-1:0] sq;
   logic s_wclk, s_rclk, s_wen_n, s_ren_n, s_mrs_n, s_mode, s_narrow;
   logic [DATA_W-1:0] s_din;
   logic wclk_d, rclk_d, wrise, rrise;
   logic narrow;
   logic [SLOT_W-1:0] mem [SLOTS];
   logic [PTR_W-1:0] wptr, rptr;
   logic [CNT_W-1:0] count, depth, eff;
   logic [DATA_W-1:0] rword;
   logic full, nonempty, do_wr, do_rd, std_rd, fall_through_mode_ld, consume;
   logic out_valid, r_s1, r_s2, w_s1, w_s2;

   function automatic logic [PTR_W-1:0] ptr_inc(
      input logic [PTR_W-1:0] p,
      input logic [CNT_W-1:0] d
   );
      ptr_inc = (CNT_W'(p) == d - CNT_ONE) ? '0 : p + PTR_W'(1);
   endfunction

   // Wide words take two neighbouring slots
   function automatic logic [PTR_W-1:0] slot(
      input logic [PTR_W-1:0] p,
      input logic hi,
      input logic nar
   );
      slot = nar ? p : {p[PTR_W-2:0], hi};
   endfunction

   // Every pin, the link clocks among them, is resynchronised before use
   dcf_sync #(.W(DEV_SYNC_W)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .d({link.narrow_bus, link.mode_select_serial_in, link.master_reset_n,
          link.ren_n, link.wen_n, link.rclk, link.wclk, link.data_in}),
      .q(sq)
   );
   assign {s_narrow, s_mode, s_mrs_n, s_ren_n, s_wen_n, s_rclk, s_wclk, s_din} = sq;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         wclk_d <= 1'h0;
         rclk_d <= 1'h0;
      end
      else if (ce)
      begin
         wclk_d <= s_wclk;
         rclk_d <= s_rclk;
      end
   end
   assign wrise = s_wclk & ~wclk_d;
   assign rrise = s_rclk & ~rclk_d;

   // Mode and width are caught only while master reset is held
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         fall_through_mode <= 1'h0;
         narrow <= 1'h0;
      end
      else if (ce && !s_mrs_n)
      begin
         fall_through_mode <= s_mode;
         narrow <= s_narrow;
      end
   end

   assign depth = narrow ? DEPTH_NARROW : DEPTH_WIDE;
   assign full = (count == depth);
   assign nonempty = (count != '0);
   assign do_wr = s_mrs_n & wrise & ~s_wen_n & ~full;
   assign std_rd = rrise & ~s_ren_n & nonempty;
   assign consume = rrise & out_valid & ~s_ren_n;
   // Output register refills once memory data has been seen for two edges
   assign fall_through_mode_ld = rrise & nonempty & r_s2 & (~out_valid | ~s_ren_n);
   assign do_rd = s_mrs_n & (fall_through_mode ? fall_through_mode_ld : std_rd);

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
      end
      else if (ce)
      begin
         if (!s_mrs_n)
         begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
         end
         else
         begin
            if (do_wr)
            begin
               wptr <= ptr_inc(wptr, depth);
            end
            if (do_rd)
            begin
               rptr <= ptr_inc(rptr, depth);
            end
            count <= count + CNT_W'(do_wr) - CNT_W'(do_rd);
         end
      end
   end

   // Storage is data only and needs no reset
   always_ff @(posedge mclk)
   begin
      if (ce && do_wr)
      begin
         mem[slot(wptr, 1'h0, narrow)] <= s_din[SLOT_W-1:0];
         if (!narrow)
         begin
            mem[slot(wptr, 1'h1, narrow)] <= s_din[DATA_W-1:SLOT_W];
         end
      end
   end

   assign rword = narrow ? DATA_W'(mem[rptr]) :
                  {mem[slot(rptr, 1'h1, narrow)], mem[slot(rptr, 1'h0, narrow)]};

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         link.data_out <= '0;
      end
      else if (ce)
      begin
         if (!s_mrs_n)
         begin
            link.data_out <= '0;
         end
         else if (do_rd)
         begin
            link.data_out <= rword;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         out_valid <= 1'h0;
      end
      else if (ce)
      begin
         if (!s_mrs_n || !fall_through_mode)
         begin
            out_valid <= 1'h0;
         end
         else if (fall_through_mode_ld)
         begin
            out_valid <= 1'h1;
         end
         else if (consume)
         begin
            out_valid <= 1'h0;
         end
      end
   end

   // Read-side and write-side views advance only on their own link clock
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         r_s1 <= 1'h0;
         r_s2 <= 1'h0;
         w_s1 <= 1'h1;
         w_s2 <= 1'h1;
      end
      else if (ce)
      begin
         if (!s_mrs_n)
         begin
            r_s1 <= 1'h0;
            r_s2 <= 1'h0;
            w_s1 <= 1'h1;
            w_s2 <= 1'h1;
         end
         else
         begin
            if (rrise)
            begin
               r_s1 <= nonempty;
               r_s2 <= r_s1;
            end
            if (wrise)
            begin
               w_s1 <= ~full;
               w_s2 <= w_s1;
            end
         end
      end
   end

   // Fall-through counts one word less than held, so thresholds sit one higher
   assign eff = (!fall_through_mode || out_valid) ? count :
                (nonempty ? count - CNT_ONE : count);

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         link.empty_flag_n <= 1'h0;
         link.full_flag_n <= 1'h1;
         link.almost_empty_flag_n <= 1'h0;
         link.almost_full_flag_n <= 1'h1;
         link.half_full_flag_n <= 1'h1;
         link.output_ready_n <= 1'h1;
         link.input_ready_n <= 1'h1;
      end
      else if (ce)
      begin
         if (!s_mrs_n)
         begin
            link.empty_flag_n <= 1'h0;
            link.full_flag_n <= 1'h1;
            link.almost_empty_flag_n <= 1'h0;
            link.almost_full_flag_n <= 1'h1;
            link.half_full_flag_n <= 1'h1;
            link.output_ready_n <= 1'h1;
            link.input_ready_n <= 1'h1;
         end
         else
         begin
            // Flags of the mode not in use idle high
            link.empty_flag_n <= fall_through_mode | r_s2;
            link.full_flag_n <= fall_through_mode | w_s2;
            link.output_ready_n <= ~(fall_through_mode & out_valid);
            link.input_ready_n <= ~(fall_through_mode & w_s2);
            link.almost_empty_flag_n <= (eff > CNT_W'(empty_offset));
            link.half_full_flag_n <= ~(eff >= (depth >> 1) + CNT_ONE);
            link.almost_full_flag_n <= ~(eff >= depth - CNT_W'(full_offset));
         end
      end
   end
endmodule
`default_nettype wire

// file: src/dcf_pkg.sv
`default_nettype none
package dcf_pkg;
   localparam int DATA_W = 18;
   localparam int SLOT_W = 9;
   localparam int PTR_W = 10;
   localparam int CNT_W = 11;
   localparam int SLOTS = 1024;
   localparam logic [CNT_W-1:0] DEPTH_WIDE = 11'h200;
   localparam logic [CNT_W-1:0] DEPTH_NARROW = 11'h400;
   localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
   // Flag positions in the host's status word
   localparam int FL_EF = 0;
   localparam int FL_FF = 1;
   localparam int FL_PAE = 2;
   localparam int FL_PAF = 3;
   localparam int FL_HF = 4;
   localparam int FL_OR = 5;
   localparam int FL_IR = 6;
   localparam int FLAG_W = 7;
   localparam int DEV_SYNC_W = 7 + DATA_W;
   localparam int HOST_SYNC_W = FLAG_W + DATA_W;
   // Link clocks made by the host
   localparam int MCLK_NS = 100;
   localparam int LINK_NS = 800;
   localparam int CLK_DIV = LINK_NS / MCLK_NS;
   localparam int DIV_W = $clog2(CLK_DIV);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_DIV - 1);
   localparam logic [DIV_W-1:0] W_RISE = DIV_W'(0);
   localparam logic [DIV_W-1:0] W_FALL = DIV_W'(CLK_DIV / 2);
   localparam logic [DIV_W-1:0] R_RISE = DIV_W'(CLK_DIV / 4);
   localparam logic [DIV_W-1:0] R_FALL = DIV_W'(CLK_DIV / 4 + CLK_DIV / 2);
   // Master reset length and idle link periods after each transfer
   localparam int MRS_HOLD = 16;
   localparam int MRS_W = 5;
   localparam logic [MRS_W-1:0] MRS_LOAD = MRS_W'(MRS_HOLD);
   localparam int LINK_GAP = 4;
   localparam int GAP_W = 3;
   localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(LINK_GAP);
   localparam logic [GAP_W-1:0] GAP_ONE = GAP_W'(1);
endpackage
`default_nettype wire

// file: src/dcf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcf_if
   import dcf_pkg::*;
();
   logic wclk;
   logic rclk;
   logic wen_n;
   logic ren_n;
   logic master_reset_n;
   logic mode_select_serial_in;
   logic narrow_bus;
   logic [DATA_W-1:0] data_in;
   logic [DATA_W-1:0] data_out;
   logic empty_flag_n;
   logic full_flag_n;
   logic almost_empty_flag_n;
   logic almost_full_flag_n;
   logic half_full_flag_n;
   logic output_ready_n;
   logic input_ready_n;
   modport fifo (
      input wclk, rclk, wen_n, ren_n, master_reset_n, mode_select_serial_in, narrow_bus,
      input data_in,
      output data_out, empty_flag_n, full_flag_n, almost_empty_flag_n,
      output almost_full_flag_n, half_full_flag_n, output_ready_n, input_ready_n
   );
   modport ctrl (
      output wclk, rclk, wen_n, ren_n, master_reset_n, mode_select_serial_in, narrow_bus,
      output data_in,
      input data_out, empty_flag_n, full_flag_n, almost_empty_flag_n,
      input almost_full_flag_n, half_full_flag_n, output_ready_n, input_ready_n
   );
endinterface
`default_nettype wire

// file: src/dcf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_sync
#(
   parameter int W = 1
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1;

   // First stage feeds only the second
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         s1 <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         s1 <= d;
         q <= s1;
      end
   end
endmodule
`default_nettype wire

// file: src/dcf_host.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_host
   import dcf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic reset_req,
   input wire logic mode_fall_through_mode,
   input wire logic narrow_sel,
   input wire logic wr_valid,
   input wire logic [DATA_W-1:0] wr_data,
   output logic wr_ready,
   input wire logic rd_req,
   output logic rd_ready,
   output logic [DATA_W-1:0] rd_data,
   output logic rd_data_valid,
   output logic [FLAG_W-1:0] status_flags,
   dcf_if.ctrl link
);
   typedef enum logic [1:0] {H_IDLE, H_DRIVE, H_GAP} dcf_hstate_t;
   dcf_hstate_t w_st, r_st;
   logic [HOST_SYNC_W-1:0] sq;
   logic [FLAG_W-1:0] sflags;
   logic [DATA_W-1:0] sdout, wbuf;
   logic [DIV_W-1:0] dcnt;
   logic [MRS_W-1:0] mrs_cnt;
   logic [GAP_W-1:0] w_gap, r_gap;
   logic busy, mode_l, nar_l, pend_w, pend_r, wfall, rfall, space, avail;

   dcf_sync #(.W(HOST_SYNC_W)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .d({link.input_ready_n, link.output_ready_n, link.half_full_flag_n,
          link.almost_full_flag_n, link.almost_empty_flag_n, link.full_flag_n,
          link.empty_flag_n, link.data_out}),
      .q(sq)
   );
   assign {sflags, sdout} = sq;

   assign busy = (mrs_cnt != '0);
   assign wfall = (dcnt == W_FALL);
   assign rfall = (dcnt == R_FALL);
   // Flags lag several link periods; the idle gap after each transfer covers it
   assign space = mode_l ? ~sflags[FL_IR] : sflags[FL_FF];
   assign avail = mode_l ? ~sflags[FL_OR] : sflags[FL_EF];
   assign wr_ready = ~busy & ~pend_w & (w_st == H_IDLE) & space;
   assign rd_ready = ~busy & ~pend_r & (r_st == H_IDLE) & avail;
   assign link.mode_select_serial_in = mode_l;
   assign link.narrow_bus = nar_l;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         dcnt <= '0;
         link.wclk <= 1'h0;
         link.rclk <= 1'h0;
         status_flags <= '0;
      end
      else if (ce)
      begin
         dcnt <= (dcnt == DIV_LAST) ? '0 : dcnt + DIV_W'(1);
         link.wclk <= (dcnt == W_RISE) ? 1'h1 : (wfall ? 1'h0 : link.wclk);
         link.rclk <= (dcnt == R_RISE) ? 1'h1 : (rfall ? 1'h0 : link.rclk);
         status_flags <= sflags;
      end
   end

   // A master reset is issued after every release of nrst
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         mrs_cnt <= MRS_LOAD;
         mode_l <= 1'h0;
         nar_l <= 1'h0;
         link.master_reset_n <= 1'h0;
      end
      else if (ce)
      begin
         if (reset_req && !busy)
         begin
            mrs_cnt <= MRS_LOAD;
            mode_l <= mode_fall_through_mode;
            nar_l <= narrow_sel;
         end
         else if (busy)
         begin
            mrs_cnt <= mrs_cnt - MRS_W'(1);
         end
         link.master_reset_n <= ~busy & ~(reset_req & ~busy);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         w_st <= H_IDLE;
         pend_w <= 1'h0;
         wbuf <= '0;
         w_gap <= '0;
         link.wen_n <= 1'h1;
         link.data_in <= '0;
      end
      else if (ce)
      begin
         if (busy)
         begin
            w_st <= H_IDLE;
            pend_w <= 1'h0;
            link.wen_n <= 1'h1;
         end
         else
         begin
            if (wr_valid && wr_ready)
            begin
               pend_w <= 1'h1;
               wbuf <= wr_data;
            end
            if (wfall)
            begin
               case (w_st)
                  H_IDLE:
                     if (pend_w)
                     begin
                        link.wen_n <= 1'h0;
                        link.data_in <= wbuf;
                        pend_w <= 1'h0;
                        w_st <= H_DRIVE;
                     end
                  H_DRIVE:
                  begin
                     link.wen_n <= 1'h1;
                     w_gap <= GAP_LOAD;
                     w_st <= H_GAP;
                  end
                  H_GAP:
                  begin
                     w_gap <= w_gap - GAP_ONE;
                     if (w_gap == GAP_ONE)
                     begin
                        w_st <= H_IDLE;
                     end
                  end
                  default: w_st <= H_IDLE;
               endcase
            end
         end
      end
   end

   // Fall-through data is taken before the fetch, standard data after it
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         r_st <= H_IDLE;
         pend_r <= 1'h0;
         r_gap <= '0;
         rd_data <= '0;
         rd_data_valid <= 1'h0;
         link.ren_n <= 1'h1;
      end
      else if (ce)
      begin
         rd_data_valid <= 1'h0;
         if (busy)
         begin
            r_st <= H_IDLE;
            pend_r <= 1'h0;
            link.ren_n <= 1'h1;
         end
         else
         begin
            if (rd_req && rd_ready)
            begin
               pend_r <= 1'h1;
            end
            if (rfall)
            begin
               case (r_st)
                  H_IDLE:
                     if (pend_r)
                     begin
                        if (mode_l)
                        begin
                           rd_data <= sdout;
                           rd_data_valid <= 1'h1;
                        end
                        link.ren_n <= 1'h0;
                        pend_r <= 1'h0;
                        r_st <= H_DRIVE;
                     end
                  H_DRIVE:
                  begin
                     link.ren_n <= 1'h1;
                     r_gap <= GAP_LOAD;
                     r_st <= H_GAP;
                  end
                  H_GAP:
                  begin
                     r_gap <= r_gap - GAP_ONE;
                     if (r_gap == GAP_ONE)
                     begin
                        if (!mode_l)
                        begin
                           rd_data <= sdout;
                           rd_data_valid <= 1'h1;
                        end
                        r_st <= H_IDLE;
                     end
                  end
                  default: r_st <= H_IDLE;
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/dcf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dcf_checker
   import dcf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic wclk,
   input wire logic rclk,
   input wire logic wen_n,
   input wire logic ren_n,
   input wire logic master_reset_n,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic almost_empty_flag_n,
   input wire logic almost_full_flag_n,
   input wire logic half_full_flag_n,
   input wire logic output_ready_n,
   input wire logic input_ready_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   sequence s_wen_pulse;
      !wen_n [*8] ##1 wen_n;
   endsequence
   sequence s_ren_cycle;
      !ren_n [*8] ##1 ren_n [*8];
   endsequence
   // Six cycles leave room for the two-flop sync inside the device
   chk_reset_flags: assert property (!master_reset_n [*6] |->
      !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n)
      else $error("flags not cleared by master reset");
   chk_wen_pulse: assert property ($fell(wen_n) |-> s_wen_pulse)
      else $error("write enable pulse length wrong");
   chk_ren_cycle: assert property ($fell(ren_n) |-> s_ren_cycle)
      else $error("read enable pulse or gap wrong");
   chk_data_hold: assert property (!wen_n && $past(!wen_n) |-> $stable(data_in))
      else $error("write data moved while enabled");
   chk_wen_edge: assert property ($changed(wen_n) |-> !wclk)
      else $error("write enable moved while write clock high");
   chk_ren_edge: assert property ($changed(ren_n) |-> !rclk)
      else $error("read enable moved while read clock high");
   chk_std_read_only: assert property (output_ready_n && input_ready_n &&
      master_reset_n && $past(master_reset_n, 8) && $changed(data_out) |-> !ren_n)
      else $error("output data changed without a read");
   chk_ef_ff_excl: assert property (!(!empty_flag_n && !full_flag_n))
      else $error("empty and full asserted together");
   chk_hf_pae: assert property (!half_full_flag_n |-> almost_empty_flag_n)
      else $error("half full while almost empty");
   chk_paf_hf: assert property (!almost_full_flag_n |-> !half_full_flag_n)
      else $error("almost full without half full");
   chk_fall_through_mode_hold: assert property (!output_ready_n |-> empty_flag_n && full_flag_n)
      else $error("standard flags active in fall-through");
endmodule
`default_nettype wire

// file: tb/dual_clock_fifo_flag_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flag_logic_bench
   import dcf_pkg::*;
;
   localparam logic [PTR_W-1:0] N_OFF = 10'h003;
   localparam logic [PTR_W-1:0] M_OFF = 10'h005;
   logic mclk, nrst, reset_req, mode_fall_through_mode, narrow_sel, wr_valid, rd_req;
   logic wr_ready, rd_ready, rd_data_valid, ftm;
   logic [DATA_W-1:0] wr_data, rd_data;
   logic [FLAG_W-1:0] status_flags;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   int depth = 512;
   bit ft_cfg = 1'b0;
   dcf_if link_if();
   dcf_device dcf_device_inst (.mclk(mclk), .nrst(nrst), .ce(1'b1), .empty_offset(N_OFF),
      .full_offset(M_OFF), .fall_through_mode(ftm), .link(link_if.fifo));
   dcf_host dcf_host_inst (.mclk(mclk), .nrst(nrst), .ce(1'b1), .reset_req(reset_req),
      .mode_fall_through_mode(mode_fall_through_mode), .narrow_sel(narrow_sel), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .rd_req(rd_req), .rd_ready(rd_ready), .rd_data(rd_data),
      .rd_data_valid(rd_data_valid), .status_flags(status_flags), .link(link_if.ctrl));
   dcf_checker dcf_checker_inst (.mclk(mclk), .nrst(nrst), .wclk(link_if.wclk),
      .rclk(link_if.rclk), .wen_n(link_if.wen_n), .ren_n(link_if.ren_n),
      .master_reset_n(link_if.master_reset_n), .data_in(link_if.data_in),
      .data_out(link_if.data_out), .empty_flag_n(link_if.empty_flag_n),
      .full_flag_n(link_if.full_flag_n), .almost_empty_flag_n(link_if.almost_empty_flag_n),
      .almost_full_flag_n(link_if.almost_full_flag_n),
      .half_full_flag_n(link_if.half_full_flag_n), .output_ready_n(link_if.output_ready_n),
      .input_ready_n(link_if.input_ready_n));
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Every transfer costs six link periods, so full runs stay near 87k cycles
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 95000)
      begin
         err_total++;
         wrap_up();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_rdy(input bit rd);
      int i;
      i = 0;
      @(negedge mclk);
      while ((rd ? rd_ready : wr_ready) !== 1'b1 && i < 400)
      begin
         @(negedge mclk);
         i++;
      end
      check("ready", i < 400, 1);
   endtask
   function automatic logic [DATA_W-1:0] dat(input int i);
      return DATA_W'(i * 37) ^ 18'h2_5A5A;
   endfunction
   // Fall-through leaves the output register out of the count, so thresholds sit one word later
   function automatic logic [FLAG_W-1:0] exp_flags(input int w, input bit ft);
      logic [FLAG_W-1:0] f;
      int e;
      e = (ft && w > 0) ? w - 1 : w;
      f[FL_EF] = ft || w > 0;
      f[FL_FF] = ft || w < depth;
      f[FL_PAE] = e > int'(N_OFF);
      f[FL_PAF] = e < depth - int'(M_OFF);
      f[FL_HF] = e < depth / 2 + 1;
      f[FL_OR] = !ft || w == 0;
      f[FL_IR] = !ft || w > depth;
      return f;
   endfunction
   task automatic flags(input int w);
      logic [FLAG_W-1:0] pins;
      repeat (4) @(negedge mclk);
      pins = {link_if.input_ready_n, link_if.output_ready_n, link_if.half_full_flag_n,
         link_if.almost_full_flag_n, link_if.almost_empty_flag_n, link_if.full_flag_n,
         link_if.empty_flag_n};
      check("pin flags", pins, exp_flags(w, ft_cfg));
      check("status", status_flags, exp_flags(w, ft_cfg));
   endtask
   task automatic put(input logic [DATA_W-1:0] d, input int w);
      int i;
      wait_rdy(0);
      @(posedge mclk);
      wr_valid <= 1'b1;
      wr_data <= d;
      @(posedge mclk);
      wr_valid <= 1'b0;
      i = 0;
      @(negedge mclk);
      while (link_if.wen_n !== 1'b0 && i < 20)
      begin
         @(negedge mclk);
         i++;
      end
      check("write issued", i < 20, 1);
      // Ready never returns once full, so wait out drive period and gap instead
      repeat (40) @(negedge mclk);
      flags(w);
      check("write ready", wr_ready, ft_cfg ? w <= depth : w < depth);
   endtask
   task automatic get(input logic [DATA_W-1:0] d, input int w);
      int i;
      wait_rdy(1);
      @(posedge mclk);
      rd_req <= 1'b1;
      @(posedge mclk);
      rd_req <= 1'b0;
      i = 0;
      @(negedge mclk);
      while (rd_data_valid !== 1'b1 && i < 100)
      begin
         @(negedge mclk);
         i++;
      end
      check("read valid", i < 100, 1);
      check("read data", rd_data, d);
      if (ft_cfg)
      begin
         repeat (40) @(negedge mclk);
      end
      flags(w);
      check("read ready", rd_ready, w > 0);
   endtask
   task automatic do_reset(input bit ft, input bit nar);
      @(posedge mclk);
      mode_fall_through_mode <= ft;
      narrow_sel <= nar;
      reset_req <= 1'b1;
      @(posedge mclk);
      reset_req <= 1'b0;
      ft_cfg = ft;
      depth = int'(nar ? DEPTH_NARROW : DEPTH_WIDE);
      repeat (4) @(posedge mclk);
      wait_rdy(0);
      check("mode", ftm, ft);
      flags(0);
   endtask
   task automatic test_reset_state();
      wait_rdy(0);
      check("mode", ftm, 1'b0);
      flags(0);
   endtask
   task automatic test_std();
      for (int i = 0; i < depth; i++) put(dat(i), i + 1);
      check("write refused", wr_ready, 1'b0);
      flags(depth);
      for (int i = 0; i < depth; i++) get(dat(i), depth - 1 - i);
      check("read refused", rd_ready, 1'b0);
      check("data held", link_if.data_out, dat(depth - 1));
   endtask
   task automatic test_narrow();
      do_reset(1'b0, 1'b1);
      for (int i = 0; i < 257; i++) put(dat(i), i + 1);
      for (int i = 0; i < 3; i++) get(dat(i) & 18'h0_01FF, 256 - i);
   endtask
   task automatic test_fall_through_mode();
      do_reset(1'b1, 1'b0);
      put(dat(0), 1);
      check("first word", link_if.data_out, dat(0));
      for (int i = 1; i <= depth; i++) put(dat(i), i + 1);
      check("write refused", wr_ready, 1'b0);
      flags(depth + 1);
      for (int i = 0; i < 3; i++) get(dat(i), depth - i);
   endtask
   initial
   begin
      nrst = 1'b0;
      reset_req = 1'b0;
      mode_fall_through_mode = 1'b0;
      narrow_sel = 1'b0;
      wr_valid = 1'b0;
      wr_data = '0;
      rd_req = 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      test_reset_state();
      test_std();
      test_narrow();
      test_fall_through_mode();
      wrap_up();
   end
endmodule
`default_nettype wire
